/* File: hdl/gcg_consts.svh */
// Purpose: constants for the gapped DS3 clock generator
// Assumes: pclk at 250 MHz; link clock is the 51.84 MHz base clock
// Notes:   definitions only
`ifndef GCG_CONSTS_SVH
`define GCG_CONSTS_SVH

// ********************************
// pclk timing
// ********************************
`define GCG_CLK_PERIOD_NS 4
`define GCG_WR_PULSE_NS   40
`define GCG_WR_PULSE_CYC  ((`GCG_WR_PULSE_NS + `GCG_CLK_PERIOD_NS - 1) / `GCG_CLK_PERIOD_NS)

// ********************************
// burst units: last phase, pulse count
// ********************************
`define GCG_U7_LAST    3'h7
`define GCG_U7_PULSES  3'h7
`define GCG_U5_LAST    3'h5
`define GCG_U5_PULSES  3'h5
`define GCG_U6_LAST    3'h5
`define GCG_U6_PULSES  3'h6

// ********************************
// repeat counts as last index (63, 36, 35, 1)
// ********************************
`define GCG_U7_REPS_LAST   6'h3e
`define GCG_U5_REPS_LAST_A 6'h23
`define GCG_U5_REPS_LAST_B 6'h22
`define GCG_U6_REPS_LAST   6'h00
`define GCG_FRAME_B        2'h2
`define GCG_FRAME_FIRST    2'h0

// ********************************
// register map (byte offsets)
// ********************************
`define GCG_OFF_CTRL  12'h000
`define GCG_OFF_JA    12'h004
`define GCG_OFF_STAT  12'h008
`define GCG_OFF_SUPER 12'h00c

`define GCG_CTRL_RUN    0
`define GCG_CTRL_JA_GO  1
`define GCG_STAT_BUSY   0
`define GCG_STAT_UNDER  1
`define GCG_STAT_EMPTY  2

// ********************************
// attenuator control fields
// ********************************
`define GCG_JA_BW_LO     0
`define GCG_JA_PATH      1
`define GCG_JA_BW_HI     2
`define GCG_JA_FLUSH     3
`define GCG_JA_FAST_OFF  4
`define GCG_ATTEN_FLUSH_VAL 8'h03
`define GCG_JA_REG_LO    4'h7
`define GCG_CH_SPLIT     4'h6
`define GCG_CH_SKIP      4'h2

`endif

/* File: hdl/gcg_pkg.sv */
// Purpose: shared types of the gapped clock generator
// Assumes: nothing
// Notes:   constants live in gcg_consts.svh
`default_nettype none
package gcg_pkg;
  typedef enum logic [1:0]
  {
    GCG_U7 = 2'b00,
    GCG_U5 = 2'b01,
    GCG_U6 = 2'b11
  } gcg_unit_e;

  typedef enum logic [1:0]
  {
    GCG_WR_IDLE   = 2'b00,
    GCG_WR_SETUP  = 2'b01,
    GCG_WR_STROBE = 2'b11,
    GCG_WR_HOLD   = 2'b10
  } gcg_wr_e;

  typedef logic [7:0] gcg_byte_t;
endpackage
`default_nettype wire

/* File: hdl/gcg_seq_if.sv */
// Purpose: carrier between generator top and burst sequencer
// Assumes: all signals in the link clock domain
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface gcg_seq_if;
  logic run;
  logic pulse;
  logic super_done;

  modport seq (input run, output pulse, output super_done);
  modport gen (output run, input pulse, input super_done);
endinterface
`default_nettype wire

/* File: hdl/gcg_burst_seq.sv */
// Purpose: nested burst pattern sequencer on the base clock
// Assumes: run already synchronised to link_clk
// Notes:   restarts at frame A while run is low
`timescale 1ns/10ps
`default_nettype none
`include "gcg_consts.svh"
module gcg_burst_seq
  import gcg_pkg::*;
(
  // link clock and reset
  input  wire logic link_clk,
  input  wire logic link_rst_n,
  // sequencer carrier
  gcg_seq_if.seq    sq
);

  gcg_unit_e  unit_ff, nxt_unit;
  logic [2:0] ph_ff, nxt_ph;
  logic [5:0] reps_ff, nxt_reps;
  logic [1:0] frm_ff, nxt_frm;
  logic       done_ff, nxt_done;

  logic [2:0] last_ph;
  logic [2:0] n_pulses;
  logic [5:0] last_rep;
  logic       unit_end;
  logic       reps_end;
  logic       frame_b;

  assign frame_b  = (frm_ff == `GCG_FRAME_B);
  assign last_ph  = (unit_ff == GCG_U7) ? `GCG_U7_LAST :
                    (unit_ff == GCG_U5) ? `GCG_U5_LAST : `GCG_U6_LAST;
  assign n_pulses = (unit_ff == GCG_U7) ? `GCG_U7_PULSES :
                    (unit_ff == GCG_U5) ? `GCG_U5_PULSES : `GCG_U6_PULSES;
  // 36 fives in frame A, 35 in frame B
  assign last_rep = (unit_ff == GCG_U7) ? `GCG_U7_REPS_LAST :
                    (unit_ff == GCG_U6) ? `GCG_U6_REPS_LAST :
                    frame_b ? `GCG_U5_REPS_LAST_B
                            : `GCG_U5_REPS_LAST_A;
  assign unit_end = (ph_ff == last_ph);
  assign reps_end = (reps_ff == last_rep);
  // pulse in leading phases, gap after the last one except in the six-pulse unit
  assign sq.pulse = sq.run && (ph_ff < n_pulses);
  assign sq.super_done = done_ff;

  always_comb
  begin
    nxt_unit = unit_ff;
    nxt_ph   = ph_ff + 3'h1;
    nxt_reps = reps_ff;
    nxt_frm  = frm_ff;
    nxt_done = 1'b0;
    if (!sq.run)
    begin
      nxt_unit = GCG_U7;
      nxt_ph   = 3'h0;
      nxt_reps = 6'h00;
      nxt_frm  = `GCG_FRAME_FIRST;
    end
    else if (unit_end)
    begin
      nxt_ph   = 3'h0;
      nxt_reps = reps_ff + 6'h01;
      if (reps_end)
      begin
        nxt_reps = 6'h00;
        unique case (unit_ff)
          GCG_U7: nxt_unit = GCG_U5;
          GCG_U5:
          begin
            nxt_unit = frame_b ? GCG_U6 : GCG_U7;
            if (!frame_b)
              nxt_frm = frm_ff + 2'h1;
          end
          GCG_U6:
          begin
            // A, A, B then wrap: 1864 pulses in 2160 periods
            nxt_unit = GCG_U7;
            nxt_frm  = `GCG_FRAME_FIRST;
            nxt_done = 1'b1;
          end
          default: nxt_unit = GCG_U7;
        endcase
      end
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      unit_ff <= GCG_U7;
      ph_ff   <= 3'h0;
      reps_ff <= 6'h00;
      frm_ff  <= `GCG_FRAME_FIRST;
      done_ff <= 1'b0;
    end
    else
    begin
      unit_ff <= nxt_unit;
      ph_ff   <= nxt_ph;
      reps_ff <= nxt_reps;
      frm_ff  <= nxt_frm;
      done_ff <= nxt_done;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/gcg_top.sv */
// Purpose: gapped DS3 clock and data generator with attenuator setup
// Assumes: link_clk is the 51.84 MHz base clock; APB slave on pclk
// Notes:   data bits enter on pclk and cross through a gray FIFO
`timescale 1ns/10ps
`default_nettype none
`include "gcg_consts.svh"
module gcg_top
  import gcg_pkg::*;
#(
  parameter int        FIFO_AW = 4,
  parameter logic [3:0] CHANNEL = 4'h0
)
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // demapped bit stream (pclk domain)
  input  wire logic        bit_in_valid,
  input  wire logic        bit_in_data,
  output logic             bit_in_ready,
  // device register port
  output logic             dev_cs_n,
  output logic             dev_wr_n,
  output logic      [7:0]  dev_addr,
  output logic      [7:0]  dev_wdata,
  // link side
  input  wire logic        link_clk,
  output logic             tx_line_clock_in,
  output logic             tx_line_data_in
);

  localparam int DEPTH = 1 << FIFO_AW;

  // ********************************
  // apb decode
  // ********************************
  wire apb_wr   = psel && penable && pwrite;
  wire apb_rd   = psel && !penable && !pwrite;
  wire sel_ctrl = (paddr == `GCG_OFF_CTRL);
  wire sel_ja   = (paddr == `GCG_OFF_JA);
  wire sel_stat = (paddr == `GCG_OFF_STAT);
  wire sel_sup  = (paddr == `GCG_OFF_SUPER);
  wire mapped   = sel_ctrl || sel_ja || sel_stat || sel_sup;

  logic        run_ff;
  gcg_byte_t   ja_ff;
  logic        under_ff, nxt_under;
  logic [31:0] super_ff;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        err_ff;
  gcg_wr_e     wr_st_ff, nxt_wr_st;
  logic [7:0]  wr_cnt_ff, nxt_wr_cnt;
  logic        under_evt;
  logic        super_evt;
  logic        fifo_empty_p;

  wire ja_go    = apb_wr && sel_ctrl && pwdata[`GCG_CTRL_JA_GO];
  wire ja_busy  = (wr_st_ff != GCG_WR_IDLE);
  wire under_clr = apb_wr && sel_stat && pwdata[`GCG_STAT_UNDER];

  // underrun sticky: a new event beats the clear
  assign nxt_under = under_evt ? 1'b1 : (under_clr ? 1'b0 : under_ff);

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (sel_ctrl)
      nxt_rdata[`GCG_CTRL_RUN] = run_ff;
    else if (sel_ja)
      nxt_rdata[7:0] = ja_ff;
    else if (sel_stat)
    begin
      nxt_rdata[`GCG_STAT_BUSY]  = ja_busy;
      nxt_rdata[`GCG_STAT_UNDER] = under_ff;
      nxt_rdata[`GCG_STAT_EMPTY] = fifo_empty_p;
    end
    else if (sel_sup)
      nxt_rdata = super_ff;
  end

  // zero wait states; read data latched in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = rdata_ff;
  assign pslverr = err_ff && psel && penable;

  // ********************************
  // control and status registers
  // ********************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_ff   <= 1'b0;
      // default: narrow desync, transmit path, fast recovery on
      ja_ff    <= `GCG_ATTEN_FLUSH_VAL;
      under_ff <= 1'b0;
      super_ff <= 32'h0000_0000;
      rdata_ff <= 32'h0000_0000;
      err_ff   <= 1'b0;
    end
    else
    begin
      if (apb_wr && sel_ctrl)
        run_ff <= pwdata[`GCG_CTRL_RUN];
      // fast_recovery_off written as software chooses
      if (apb_wr && sel_ja && !ja_busy)
        ja_ff <= pwdata[7:0];
      under_ff <= nxt_under;
      if (super_evt)
        super_ff <= super_ff + 32'h0000_0001;
      if (apb_rd)
        rdata_ff <= nxt_rdata;
      if (psel && !penable)
        err_ff <= !mapped;
    end
  end

  // ********************************
  // device register write
  // ********************************
  // register 0xM7, M skips 6 and 7 for upper channels
  wire [3:0] dev_hi = (CHANNEL < `GCG_CH_SPLIT) ? CHANNEL
                                                : CHANNEL + `GCG_CH_SKIP;
  wire       strobe_done = (wr_cnt_ff == 8'(`GCG_WR_PULSE_CYC - 1));

  always_comb
  begin
    nxt_wr_st  = wr_st_ff;
    nxt_wr_cnt = 8'h00;
    unique case (wr_st_ff)
      GCG_WR_IDLE:
        if (ja_go)
          nxt_wr_st = GCG_WR_SETUP;
      GCG_WR_SETUP:
        nxt_wr_st = GCG_WR_STROBE;
      GCG_WR_STROBE:
      begin
        nxt_wr_cnt = wr_cnt_ff + 8'h01;
        if (strobe_done)
          nxt_wr_st = GCG_WR_HOLD;
      end
      GCG_WR_HOLD:
        nxt_wr_st = GCG_WR_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_st_ff  <= GCG_WR_IDLE;
      wr_cnt_ff <= 8'h00;
      dev_cs_n  <= 1'b1;
      dev_wr_n  <= 1'b1;
      dev_addr  <= 8'h00;
      dev_wdata <= 8'h00;
    end
    else
    begin
      wr_st_ff  <= nxt_wr_st;
      wr_cnt_ff <= nxt_wr_cnt;
      dev_cs_n  <= (nxt_wr_st == GCG_WR_IDLE);
      dev_wr_n  <= (nxt_wr_st != GCG_WR_STROBE);
      if (wr_st_ff == GCG_WR_IDLE && ja_go)
      begin
        dev_addr  <= {dev_hi, `GCG_JA_REG_LO};
        dev_wdata <= ja_ff;
      end
    end
  end

  // ********************************
  // elastic buffer, write side (pclk)
  // ********************************
  logic               mem [DEPTH];
  logic [FIFO_AW:0]   wbin_ff, wgray_ff;
  logic [FIFO_AW:0]   rg_s1_ff, rg_s2_ff;
  logic [FIFO_AW:0]   rbin_ff, rgray_ff;
  logic [FIFO_AW:0]   wg_s1_ff, wg_s2_ff;

  wire [FIFO_AW:0] wbin_nxt  = wbin_ff + 1'b1;
  wire [FIFO_AW:0] wgray_nxt = wbin_nxt ^ (wbin_nxt >> 1);
  wire fifo_full = (wgray_ff == {~rg_s2_ff[FIFO_AW:FIFO_AW-1],
                                 rg_s2_ff[FIFO_AW-2:0]});
  assign bit_in_ready = !fifo_full;
  assign fifo_empty_p = (wgray_ff == rg_s2_ff);
  wire push = bit_in_valid && !fifo_full;

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wbin_ff[FIFO_AW-1:0]] <= bit_in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wbin_ff  <= '0;
      wgray_ff <= '0;
      rg_s1_ff <= '0;
      rg_s2_ff <= '0;
    end
    else
    begin
      rg_s1_ff <= rgray_ff;
      rg_s2_ff <= rg_s1_ff;
      if (push)
      begin
        wbin_ff  <= wbin_nxt;
        wgray_ff <= wgray_nxt;
      end
    end
  end

  // ********************************
  // link domain reset and run
  // ********************************
  logic lrst_s1_ff, link_rst_n;
  logic run_s1_ff, run_s2_ff;

  always_ff @(posedge link_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      lrst_s1_ff <= 1'b0;
      link_rst_n <= 1'b0;
      run_s1_ff  <= 1'b0;
      run_s2_ff  <= 1'b0;
    end
    else
    begin
      lrst_s1_ff <= 1'b1;
      link_rst_n <= lrst_s1_ff;
      run_s1_ff  <= run_ff;
      run_s2_ff  <= run_s1_ff;
    end
  end

  gcg_seq_if sq ();
  assign sq.run = run_s2_ff;

  gcg_burst_seq u_seq
  (
    .link_clk   (link_clk),
    .link_rst_n (link_rst_n),
    .sq         (sq.seq)
  );

  // ********************************
  // elastic buffer, read side and line drive
  // ********************************
  logic gate_ff;
  logic data_ff;
  logic under_tg_ff;
  logic super_tg_ff;

  wire [FIFO_AW:0] rbin_nxt  = rbin_ff + 1'b1;
  wire [FIFO_AW:0] rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
  wire fifo_empty_l = (rgray_ff == wg_s2_ff);
  wire pop = sq.pulse && !fifo_empty_l;

  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      wg_s1_ff    <= '0;
      wg_s2_ff    <= '0;
      rbin_ff     <= '0;
      rgray_ff    <= '0;
      gate_ff     <= 1'b0;
      data_ff     <= 1'b0;
      under_tg_ff <= 1'b0;
      super_tg_ff <= 1'b0;
    end
    else
    begin
      wg_s1_ff <= wgray_ff;
      wg_s2_ff <= wg_s1_ff;
      gate_ff  <= sq.pulse;
      if (pop)
      begin
        // data moves only with a pulse, held across gaps
        data_ff  <= mem[rbin_ff[FIFO_AW-1:0]];
        rbin_ff  <= rbin_nxt;
        rgray_ff <= rgray_nxt;
      end
      if (sq.pulse && fifo_empty_l)
        under_tg_ff <= !under_tg_ff;
      if (sq.super_done)
        super_tg_ff <= !super_tg_ff;
    end
  end

  // pulse is the low half of a base period: rises mid-period,
  // half a period after data settles; gate changes while low
  assign tx_line_clock_in = gate_ff && !link_clk;
  assign tx_line_data_in  = data_ff;

  // ********************************
  // link events back to pclk
  // ********************************
  logic [2:0] under_sync_ff;
  logic [2:0] super_sync_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      under_sync_ff <= 3'b000;
      super_sync_ff <= 3'b000;
    end
    else
    begin
      under_sync_ff <= {under_sync_ff[1:0], under_tg_ff};
      super_sync_ff <= {super_sync_ff[1:0], super_tg_ff};
    end
  end

  assign under_evt = under_sync_ff[2] ^ under_sync_ff[1];
  assign super_evt = super_sync_ff[2] ^ super_sync_ff[1];

endmodule
`default_nettype wire

/* File: tb/gcg_top_properties.sv */
// Purpose: port assertions for the gapped clock generator
// Assumes: run is never cleared once set; reset restarts everything
// Notes:   link checks sample at the link clock rise, except a_pulse_low_half at pclk
`timescale 1ns/10ps
`default_nettype none
module gcg_top_chk
(
  // clocks and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        link_clk,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  // device port
  input wire logic        dev_cs_n,
  input wire logic        dev_wr_n,
  input wire logic [7:0]  dev_wdata,
  // link
  input wire logic        tx_line_clock_in,
  input wire logic        tx_line_data_in
);
  // ************************************
  // pattern bookkeeping from first pulse
  // ************************************
  logic        seen_ff;
  logic [3:0]  run_ff;
  logic [11:0] per_ff;
  logic [11:0] pc_ff;
  wire         wrap   = per_ff == 12'h86f;
  wire  [11:0] pc_now = pc_ff + {11'h000, tx_line_clock_in};
  wire         idle   = !seen_ff && !tx_line_clock_in;

  always_ff @(posedge link_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen_ff <= 1'h0;
      run_ff  <= 4'h0;
      per_ff  <= 12'h000;
      pc_ff   <= 12'h000;
    end
    else
    begin
      seen_ff <= seen_ff | tx_line_clock_in;
      run_ff  <= tx_line_clock_in ? run_ff + 4'h1 : 4'h0;
      per_ff  <= (idle || wrap) ? 12'h000 : per_ff + 12'h001;
      pc_ff   <= wrap ? 12'h000 : pc_now;
    end
  end

  // ************************************
  // assertions
  // ************************************
  a_err_unmapped:
    assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && paddr > 12'h00c |-> pslverr)
    else $error("no error flag on unmapped access");
  a_strobe_width:
    assert property (@(posedge pclk) disable iff (!presetn)
      $fell(dev_wr_n) |-> (!dev_wr_n && !dev_cs_n)[*8] ##1 (!dev_wr_n)[*2]
      ##1 (dev_wr_n && !dev_cs_n) ##1 dev_cs_n)
    else $error("device write strobe shape wrong");
  a_data_steady:
    assert property (@(posedge pclk) disable iff (!presetn)
      !dev_cs_n && !$past(dev_cs_n) |-> $stable(dev_wdata))
    else $error("device data moved while selected");
  a_pulse_low_half:
    assert property (@(posedge pclk) disable iff (!presetn)
      tx_line_clock_in |-> !link_clk)
    else $error("gapped pulse outside base clock low half");
  a_data_on_pulse:
    assert property (@(posedge link_clk) disable iff (!presetn)
      $changed(tx_line_data_in) |-> tx_line_clock_in)
    else $error("data changed in a gap period");
  a_burst_len:
    assert property (@(posedge link_clk) disable iff (!presetn)
      !tx_line_clock_in && run_ff != 4'h0 |-> run_ff inside {4'h5, 4'h7, 4'hd})
    else $error("pulse burst of wrong length");
  a_single_gap:
    assert property (@(posedge link_clk) disable iff (!presetn)
      seen_ff && !tx_line_clock_in |=> tx_line_clock_in)
    else $error("gap longer than one period");
  a_frame_count:
    assert property (@(posedge link_clk) disable iff (!presetn)
      seen_ff && (per_ff == 12'h2cf || per_ff == 12'h59f)
      |-> pc_now == (per_ff == 12'h2cf ? 12'h26d : 12'h4da))
    else $error("frame pulse count wrong");
  a_super_count:
    assert property (@(posedge link_clk) disable iff (!presetn)
      seen_ff && wrap |-> pc_now == 12'h748)
    else $error("super pattern pulse count wrong");
endmodule

bind gcg_top gcg_top_chk u_chk
(
  .pclk, .presetn, .link_clk, .psel, .penable, .paddr, .pslverr,
  .dev_cs_n, .dev_wr_n, .dev_wdata, .tx_line_clock_in, .tx_line_data_in
);
`default_nettype wire

/* File: tb/gcg_liu_model.sv */
// Purpose: line interface model: attenuator register and data capture
// Assumes: register write lands on the strobe's rising edge
// Notes:   keeps the first 4096 latched bits
`timescale 1ns/10ps
`default_nettype none
module gcg_liu_model
#(
  parameter logic [3:0] CHANNEL = 4'h0,
  parameter int         BASE_NS = 160
)
(
  // reset
  input  wire logic        rst_n,
  // register port
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  // line side
  input  wire logic        line_clk,
  input  wire logic        line_data,
  // observation
  output logic      [7:0]  ja_q,
  output logic      [12:0] rx_cnt,
  output logic             gap_err
);
  // ************************************
  // register store and line capture
  // ************************************
  wire  [3:0] blk     = CHANNEL < 4'h6 ? CHANNEL : CHANNEL + 4'h2;
  wire  [7:0] ja_addr = {blk, 4'h7};
  logic       rx_bits [0:4095];
  realtime    last_rise;

  // upper three bits read as zero
  always @(posedge wr_n or negedge rst_n)
    if (!rst_n)
      ja_q <= 8'h01;
    else if (!cs_n && addr == ja_addr)
      ja_q <= wdata & 8'h1f;

  always @(posedge line_clk or negedge rst_n)
    if (!rst_n)
    begin
      rx_cnt    <= 13'h0000;
      gap_err   <= 1'h0;
      last_rise = 0;
    end
    else
    begin
      if (rx_cnt < 13'h1000)
        rx_bits[rx_cnt[11:0]] <= line_data;
      rx_cnt <= rx_cnt + 13'h0001;
      if (last_rise > 0 && $realtime - last_rise > 60 * BASE_NS + 1)
        gap_err <= 1'h1;
      last_rise = $realtime;
    end
endmodule
`default_nettype wire

/* File: tb/ds3_gapped_clock_pattern_gen_tb.sv */
// Purpose: self-checking bench for the gapped clock generator
// Assumes: run stays set once started
// Notes:   one super pattern takes about 86k pclk cycles
`timescale 1ns/10ps
`default_nettype none
module ds3_gapped_clock_pattern_gen_tb;
  // ************************************
  // signals, clocks, instances
  // ************************************
  logic        pclk = 1'h0, link_clk = 1'h0, presetn = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, bit_in_ready, dev_cs_n, dev_wr_n;
  logic        bit_in_valid = 1'h0, bit_in_data = 1'h0;
  logic        tx_clk, tx_data, gap_err;
  logic [7:0]  dev_addr, dev_wdata, ja_q;
  logic [12:0] rx_cnt;
  logic [15:0] k = 16'h0000;
  logic [31:0] tbl [4] = '{32'h0000_0001, 32'h0000_0003,
                           32'h0000_0013, 32'h0000_0003};
  int          errors = 0, cmp_count = 0, i, n;

  initial forever #2 pclk = ~pclk;
  initial #37 forever #80 link_clk = ~link_clk;

  gcg_top #(.FIFO_AW(4), .CHANNEL(4'h7)) dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bit_in_valid, .bit_in_data, .bit_in_ready,
    .dev_cs_n, .dev_wr_n, .dev_addr, .dev_wdata, .link_clk,
    .tx_line_clock_in(tx_clk), .tx_line_data_in(tx_data)
  );

  gcg_liu_model #(.CHANNEL(4'h7)) liu
  (
    .rst_n(presetn), .cs_n(dev_cs_n), .wr_n(dev_wr_n), .addr(dev_addr),
    .wdata(dev_wdata), .line_clk(tx_clk), .line_data(tx_data), .ja_q,
    .rx_cnt, .gap_err
  );

  // ************************************
  // stream feed, checks, bus tasks
  // ************************************
  function automatic logic pat(input logic [15:0] x);
    return x[0] ^ x[3] ^ x[7];
  endfunction

  always @(posedge pclk)
    if (bit_in_valid && bit_in_ready)
    begin
      k           <= k + 16'h0001;
      bit_in_data <= pat(k + 16'h0001);
    end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 50)
    begin
      errors++;
      print_verdict();
    end
  endtask

  // polls a register until the masked value matches
  task automatic poll(input logic [11:0] a, input logic [31:0] m, w,
                      input int limit);
    int t;
    t = 0;
    do
    begin
      apb(1'h0, a, 32'h0000_0000);
      t++;
    end
    while ((rd & m) !== w && t < limit);
    if ((rd & m) !== w)
    begin
      errors++;
      print_verdict();
    end
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    // a real falling edge, so every async reset fires in both domains
    presetn      <= 1'h0;
    repeat (20) @(posedge pclk);
    presetn      <= 1'h1;
    bit_in_valid <= 1'h1;
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk("atten_flush", rd, 32'h0000_0003);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk("ctrl reset", rd, 32'h0000_0000);
    apb(1'h0, 12'h010, 32'h0000_0000);
    chk("unmapped err", {31'h0000_0000, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("device reset", {24'h00_0000, ja_q}, 32'h0000_0001);
    $display("test reset done");
    for (i = 0; i < 4; i++)
    begin
      apb(1'h1, 12'h004, tbl[i]);
      apb(1'h1, 12'h000, 32'h0000_0002);
      apb(1'h1, 12'h004, 32'h0000_00ff);
      apb(1'h0, 12'h004, 32'h0000_0000);
      chk("ja busy write", rd, tbl[i]);
      poll(12'h008, 32'h0000_0001, 32'h0000_0000, 40);
      chk("device addr", {24'h00_0000, dev_addr}, 32'h0000_0097);
      chk("device ja", {24'h00_0000, ja_q}, tbl[i]);
    end
    chk("no pulse idle", {19'h0_0000, rx_cnt}, 32'h0000_0000);
    $display("test device write done");
    apb(1'h1, 12'h000, 32'h0000_0001);
    poll(12'h00c, 32'hffff_ffff, 32'h0000_0001, 30000);
    chk("super count", rd, 32'h0000_0001);
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk("underrun", rd & 32'h0000_0002, 32'h0000_0000);
    chk("gap tolerance", {31'h0000_0000, gap_err}, 32'h0000_0000);
    chk("bit count", {31'h0000_0000, rx_cnt >= 13'h0748},
        32'h0000_0001);
    for (i = 0; i < 1864; i++)
      chk("line bit", {31'h0000_0000, liu.rx_bits[i]},
          {31'h0000_0000, pat(i[15:0])});
    $display("test super pattern done");
    print_verdict();
  end
endmodule
`default_nettype wire
